// *** common/ivl_pkg.sv ***
// Package with constants and types for the interrupt vector logic
package ivl_pkg;

  // ****************************************************************
  // Source numbering
  // ****************************************************************
  localparam int unsigned IVL_NUM_SRC = 11;
  localparam int unsigned IVL_NUM_PERIPH = 8;
  localparam int unsigned IVL_PC_W = 16;

  // Peripheral flag bit positions
  localparam int unsigned IVL_P_TIMER_ONE = 0;
  localparam int unsigned IVL_P_TIMER_TWO = 1;
  localparam int unsigned IVL_P_TIMER_THREE = 2;
  localparam int unsigned IVL_P_TXE = 3;
  localparam int unsigned IVL_P_RXF = 4;
  localparam int unsigned IVL_P_CAP1 = 5;
  localparam int unsigned IVL_P_CAP2 = 6;
  localparam int unsigned IVL_P_PBCH = 7;

  // ****************************************************************
  // Vector addresses and reset values
  // ****************************************************************
  localparam logic [15:0] IVL_VEC_EXT = 16'h0008;
  localparam logic [15:0] IVL_VEC_TZO = 16'h0010;
  localparam logic [15:0] IVL_VEC_TCK = 16'h0018;
  localparam logic [15:0] IVL_VEC_PER = 16'h0020;
  localparam logic IVL_GID_RST = 1'b1;
  localparam logic [7:0] IVL_PFLAG_RST = 8'h00;
  localparam logic [2:0] IVL_CFLAG_RST = 3'h0;

  // Core (dedicated vector) flag positions
  localparam int unsigned IVL_C_EXT = 0;
  localparam int unsigned IVL_C_TZO = 1;
  localparam int unsigned IVL_C_TCK = 2;

  // Vector selection, in priority order
  typedef enum logic [1:0] {
    IVL_SEL_EXT,
    IVL_SEL_TZO,
    IVL_SEL_TCK,
    IVL_SEL_PER
  } ivl_sel_t;

  // Request towards the core sequencer
  typedef struct packed {
    logic valid;
    ivl_sel_t sel;
    logic [15:0] vector;
  } ivl_req_t;

  // Software write of the peripheral and dedicated flag bits
  typedef struct packed {
    logic wr;
    logic [7:0] pflag_wdata;
    logic [2:0] cflag_wdata;
  } ivl_flag_wr_t;

endpackage

// *** hdl/ivl_pend.sv ***
// Sticky flag bits: hardware set wins over software and auto clear
`timescale 1ns/1ps
module ivl_pend #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Events and clears
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Flags
  output logic [WIDTH-1:0] flag_o
);
  import ivl_pkg::*;

  logic [WIDTH-1:0] flag_ff;
  logic [WIDTH-1:0] nxt_flag;

  initial begin
    if (WIDTH < 1) $error("ivl_pend: WIDTH must be at least 1");
  end

  // Per bit: event set beats any clear in the same cycle
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      nxt_flag[i] = flag_ff[i];
      if (wr_i) begin
        nxt_flag[i] = wdata_i[i];
      end
      if (clr_i[i]) begin
        nxt_flag[i] = 1'b0;
      end
      if (set_i[i]) begin
        nxt_flag[i] = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;
endmodule

// *** hdl/ivl_prio.sv ***
// Vector selection among pending enabled sources
`timescale 1ns/1ps
module ivl_prio (
  // Pending and enabled core sources, peripheral summary
  input wire logic [2:0] core_act_i,
  input wire logic per_act_i,
  // Selection
  output logic any_o,
  output ivl_pkg::ivl_sel_t sel_o,
  output logic [15:0] vec_o
);
  import ivl_pkg::*;

  // Fixed priority: pin, timer zero, clock pin edge, peripherals
  always_comb begin
    any_o = 1'b1;
    sel_o = IVL_SEL_PER;
    vec_o = IVL_VEC_PER;
    if (core_act_i[IVL_C_EXT]) begin
      sel_o = IVL_SEL_EXT;
      vec_o = IVL_VEC_EXT;
    end else if (core_act_i[IVL_C_TZO]) begin
      sel_o = IVL_SEL_TZO;
      vec_o = IVL_VEC_TZO;
    end else if (core_act_i[IVL_C_TCK]) begin
      sel_o = IVL_SEL_TCK;
      vec_o = IVL_VEC_TCK;
    end else if (!per_act_i) begin
      any_o = 1'b0;
    end
  end
endmodule

// *** hdl/ivl_top.sv ***
// Interrupt vector logic: flags, masks, global disable, core vectoring
// Function
// RULE1: eleven sources each own a flag bit
// RULE2: global disable set blocks every response
// RULE3: response sets global disable automatically
// RULE4: response pushes return address, loads vector
// RULE5: four vectors; peripherals share one
// RULE6: pin, timer zero, clock edge dedicated
// RULE7: dedicated vector entry clears its flag
// RULE8: peripheral vector entry leaves flags alone
// RULE9: software tests peripheral flags to identify
// RULE10: software clears peripheral flags before re-enable
// RULE11: flags set regardless of masks
// RULE12: pin response waits for instruction end
// RULE13: return op pops, clears global disable
// RULE14: request needs flag, mask, disable clear
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ivl_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Source events, one-cycle pulses
  input wire logic external_interrupt_pin_i,
  input wire logic port_b_change_i,
  input wire logic timer_zero_ovf_i,
  input wire logic timer_one_ovf_i,
  input wire logic timer_two_ovf_i,
  input wire logic timer_three_ovf_i,
  input wire logic serial_tx_empty_i,
  input wire logic serial_rx_full_i,
  input wire logic capture_unit_one_i,
  input wire logic capture_unit_two_i,
  input wire logic timer_zero_clock_pin_edge_i,
  // Core sequencer handshake
  input wire logic insn_boundary_i,
  input wire logic [15:0] next_pc_i,
  input wire logic return_from_interrupt_op_i,
  input wire logic [15:0] stack_top_i,
  // Software register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Towards the core
  output logic irq_pending_o,
  output logic vector_load_o,
  output logic [15:0] vector_pc_o,
  output logic stack_push_o,
  output logic [15:0] stack_push_data_o,
  output logic stack_pop_o,
  output logic global_interrupt_disable_o
);
  import ivl_pkg::*;

  // ****************************************************************
  // Register offsets and bit fields
  // ****************************************************************
  localparam logic [1:0] OFS_CPU = 2'h0;
  localparam logic [1:0] OFS_STA = 2'h1;
  localparam logic [1:0] OFS_PIE = 2'h2;
  localparam logic [1:0] OFS_PIR = 2'h3;
  localparam int unsigned B_GID = 4;
  localparam int unsigned B_MASK_LO = 0;
  localparam int unsigned B_FLAG_LO = 4;
  localparam int unsigned C_NUM = 3;
  localparam int unsigned M_NUM = 4;

  // ****************************************************************
  // Elaboration guards
  // ****************************************************************
  // Flag and mask fields must fit the byte-wide register port
  if (IVL_NUM_PERIPH != $bits(wdata_i)) begin : g_bad_periph
    $error("ivl_top: peripheral flags must fill one register");
  end
  if (IVL_NUM_SRC != IVL_NUM_PERIPH + C_NUM) begin : g_bad_src
    $error("ivl_top: source count does not match the flag layout");
  end
  if (B_FLAG_LO + C_NUM > $bits(wdata_i)) begin : g_bad_cflag
    $error("ivl_top: dedicated flags overflow the status register");
  end
  if (B_MASK_LO + M_NUM > B_FLAG_LO) begin : g_bad_mask
    $error("ivl_top: mask field overlaps the flag field");
  end
  // Return addresses and vectors share the program counter width
  if (IVL_PC_W != $bits(next_pc_i)) begin : g_bad_pc
    $error("ivl_top: program counter width mismatch");
  end
  // Entry points adjacent in priority order must differ, or handlers would alias
  if (IVL_VEC_EXT == IVL_VEC_TZO || IVL_VEC_TZO == IVL_VEC_TCK ||
      IVL_VEC_TCK == IVL_VEC_PER) begin : g_bad_vec
    $error("ivl_top: vector addresses must differ");
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  logic [IVL_NUM_PERIPH-1:0] p_set;
  logic [IVL_NUM_PERIPH-1:0] p_flag;
  logic [2:0] c_set;
  logic [2:0] c_clr;
  logic [2:0] c_flag;
  logic wr_pir;
  logic wr_sta;

  // Every event raises its flag whatever the masks say
  assign p_set = {port_b_change_i, capture_unit_two_i, capture_unit_one_i,
                  serial_rx_full_i, serial_tx_empty_i, timer_three_ovf_i,
                  timer_two_ovf_i, timer_one_ovf_i}; // RULE1 RULE11
  assign c_set = {timer_zero_clock_pin_edge_i, timer_zero_ovf_i,
                  external_interrupt_pin_i}; // RULE1 RULE11
  assign wr_pir = wr_i && (addr_i == OFS_PIR);
  assign wr_sta = wr_i && (addr_i == OFS_STA);

  // Peripheral flags only ever cleared by software
  ivl_pend #(
    .WIDTH(IVL_NUM_PERIPH)
  ) u_pflag (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(p_set),
    .clr_i('0), // RULE8
    .wr_i(wr_pir), // RULE10
    .wdata_i(wdata_i),
    .flag_o(p_flag)
  );

  // Dedicated flags also auto-cleared on their vector entry
  ivl_pend #(
    .WIDTH(3)
  ) u_cflag (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(c_set),
    .clr_i(c_clr), // RULE7
    .wr_i(wr_sta),
    .wdata_i(wdata_i[B_FLAG_LO+C_NUM-1:B_FLAG_LO]),
    .flag_o(c_flag)
  );

  // ****************************************************************
  // Masks and global disable
  // ****************************************************************
  logic [7:0] pie_ff;
  logic [7:0] nxt_pie;
  logic [3:0] cmask_ff;
  logic [3:0] nxt_cmask;
  logic gid_ff;
  logic nxt_gid;
  logic take;
  logic ret_ok;
  logic take_ff;
  logic nxt_take;

  // A CPU register write loads disable from bit 4, an accepted return clears it, response sets it over both
  always_comb begin
    nxt_pie = pie_ff;
    nxt_cmask = cmask_ff;
    nxt_gid = gid_ff;
    if (wr_i && addr_i == OFS_PIE) begin
      nxt_pie = wdata_i;
    end
    if (wr_sta) begin
      nxt_cmask = wdata_i[B_MASK_LO+M_NUM-1:B_MASK_LO];
    end
    if (wr_i && addr_i == OFS_CPU) begin
      nxt_gid = wdata_i[B_GID];
    end
    if (ret_ok) begin
      nxt_gid = 1'b0; // RULE13
    end
    if (take) begin
      nxt_gid = 1'b1; // RULE3
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pie_ff <= IVL_PFLAG_RST;
      cmask_ff <= '0;
      gid_ff <= IVL_GID_RST;
    end else begin
      pie_ff <= nxt_pie;
      cmask_ff <= nxt_cmask;
      gid_ff <= nxt_gid;
    end
  end

  // ****************************************************************
  // Request and vector choice
  // ****************************************************************
  logic [2:0] c_act;
  logic p_act;
  logic any_act;
  ivl_sel_t sel;
  logic [15:0] vec;

  // Masked sources; cmask bit 3 gates the peripheral group
  assign c_act = c_flag & cmask_ff[2:0]; // RULE14
  assign p_act = cmask_ff[3] && |(p_flag & pie_ff); // RULE14

  ivl_prio u_prio (
    .core_act_i(c_act),
    .per_act_i(p_act),
    .any_o(any_act),
    .sel_o(sel),
    .vec_o(vec)
  );

  // Taken only at an instruction boundary, so a two-cycle op delays it
  // A return in the entry cycle is dropped; the core cannot issue one there
  assign take = any_act && !gid_ff && insn_boundary_i && !take_ff; // RULE2 RULE12
  assign ret_ok = return_from_interrupt_op_i && !take_ff;

  // Clear only the dedicated flag whose vector is entered
  always_comb begin
    c_clr = '0;
    if (take) begin
      case (sel)
        IVL_SEL_EXT: c_clr[IVL_C_EXT] = 1'b1; // RULE7
        IVL_SEL_TZO: c_clr[IVL_C_TZO] = 1'b1; // RULE7
        IVL_SEL_TCK: c_clr[IVL_C_TCK] = 1'b1; // RULE7
        default: c_clr = '0; // RULE8
      endcase
    end
  end

  // ****************************************************************
  // Outputs to the core, all registered
  // ****************************************************************
  logic [15:0] vpc_ff;
  logic [15:0] nxt_vpc;
  logic [15:0] push_ff;
  logic [15:0] nxt_push;
  logic pop_ff;
  logic nxt_pop;
  logic pend_ff;
  logic nxt_pend;

  always_comb begin
    nxt_take = take; // RULE4
    nxt_vpc = take ? vec : vpc_ff; // RULE4 RULE5 RULE6
    nxt_push = take ? next_pc_i : push_ff; // RULE4
    nxt_pop = ret_ok; // RULE13
    nxt_pend = any_act && !nxt_gid; // RULE14
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      take_ff <= 1'b0;
      vpc_ff <= '0;
      push_ff <= '0;
      pop_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      take_ff <= nxt_take;
      vpc_ff <= nxt_vpc;
      push_ff <= nxt_push;
      pop_ff <= nxt_pop;
      pend_ff <= nxt_pend;
    end
  end

  // ****************************************************************
  // Read port, data one cycle after the strobe
  // ****************************************************************
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;

  // Peripheral flags readable so the handler can find its source
  always_comb begin
    nxt_rd = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_CPU: nxt_rd[B_GID] = gid_ff;
        OFS_STA: nxt_rd = {1'b0, c_flag, cmask_ff};
        OFS_PIE: nxt_rd = pie_ff;
        OFS_PIR: nxt_rd = p_flag; // RULE9
        default: nxt_rd = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign rdata_o = rd_ff;
  assign irq_pending_o = pend_ff;
  assign vector_load_o = take_ff;
  assign vector_pc_o = vpc_ff;
  assign stack_push_o = take_ff;
  assign stack_push_data_o = push_ff;
  assign stack_pop_o = pop_ff;
  assign global_interrupt_disable_o = gid_ff;
  // stack_top_i is consumed by the core itself on the pop
  logic unused_top;
  assign unused_top = ^stack_top_i;
endmodule

// *** verif/interrupt_vector_logic_bench.sv ***
// Self-checking bench of the interrupt vector logic
`timescale 1ns/1ps
module interrupt_vector_logic_bench;
  import ivl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [10:0] ev = '0;
  logic [1:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0, rd = 1'b0, stall = 1'b0, ret_req = 1'b0;
  logic insn_b, ret_op, irq_p, vload, push, pop, gid;
  logic [15:0] npc, top, vpc, pdata;
  logic [7:0] rdata;
  int miscompares = 0;
  int checks_done = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  // ************************************
  // Instances
  // ************************************
  ivl_core_model ivl_core_model_inst (.ref_clk_i, .rst_n_i, .stall_i(stall), .ret_req_i(ret_req),
    .stack_push_i(push), .stack_push_data_i(pdata), .stack_pop_i(pop), .insn_boundary_o(insn_b),
    .next_pc_o(npc), .return_op_o(ret_op), .stack_top_o(top));
  ivl_top ivl_top_inst (.ref_clk_i, .rst_n_i, .external_interrupt_pin_i(ev[0]),
    .timer_zero_ovf_i(ev[1]), .timer_zero_clock_pin_edge_i(ev[2]), .timer_one_ovf_i(ev[3]),
    .timer_two_ovf_i(ev[4]), .timer_three_ovf_i(ev[5]), .serial_tx_empty_i(ev[6]),
    .serial_rx_full_i(ev[7]), .capture_unit_one_i(ev[8]), .capture_unit_two_i(ev[9]),
    .port_b_change_i(ev[10]), .insn_boundary_i(insn_b), .next_pc_i(npc),
    .return_from_interrupt_op_i(ret_op), .stack_top_i(top), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_pending_o(irq_p), .vector_load_o(vload),
    .vector_pc_o(vpc), .stack_push_o(push), .stack_push_data_o(pdata), .stack_pop_o(pop),
    .global_interrupt_disable_o(gid));
  // ************************************
  // Shared tasks
  // ************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    // Keeps a following write from touching the strobe in the same step
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [1:0] a, logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk("rdata", 16'(exp), 16'(rdata));
  endtask
  task automatic pulse(logic [10:0] m);
    ev <= m;
    @(posedge ref_clk_i);
    ev <= '0;
  endtask
  // Arms masks, opens the gate, fires; hold keeps the core mid-instruction
  task automatic enter(int idx, logic [7:0] c, logic [7:0] p, logic [15:0] vec, int hold);
    int n;
    wr_reg(2'h1, c);
    wr_reg(2'h2, p);
    wr_reg(2'h0, 8'h00);
    stall <= (hold > 0);
    pulse(11'h001 << idx);
    for (n = 0; n < hold; n++) begin
      @(posedge ref_clk_i);
      #1;
      chk("early load", 16'h0, 16'(vload));
      chk("held pending", 16'h1, 16'(irq_p));
    end
    stall <= 1'b0;
    for (n = 0; n < 8 && vload !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (vload !== 1'b1) begin
      miscompares++;
      $display("Error vector load expected 1 seen %b", vload);
      final_report();
    end
    chk("vector", vec, vpc);
    chk("disable", 16'h1, 16'(gid));
    chk("push", 16'h1, 16'(push));
    chk("return address", npc - 16'h0001, pdata);
  endtask
  task automatic leave();
    ret_req <= 1'b1;
    @(posedge ref_clk_i);
    ret_req <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("pop", 16'h1, 16'(pop));
    chk("disable", 16'h0, 16'(gid));
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_blocked();
    int n;
    chk("disable reset", 16'h1, 16'(gid));
    wr_reg(2'h1, 8'h0f);
    wr_reg(2'h2, 8'hff);
    pulse(11'h7ff);
    for (n = 0; n < 4; n++) begin
      @(posedge ref_clk_i);
      #1;
      chk("blocked load", 16'h0, 16'(vload));
    end
    rd_reg(2'h1, 8'h7f);
    rd_reg(2'h3, 8'hff);
    wr_reg(2'h3, 8'h00);
    $display("test blocked done");
  endtask
  task automatic t_dedicated();
    logic [15:0] vecs [3] = '{IVL_VEC_EXT, IVL_VEC_TZO, IVL_VEC_TCK};
    int i;
    for (i = 0; i < 3; i++) begin
      enter(i, 8'h01 << i, 8'h00, vecs[i], 3 * i);
      rd_reg(2'h1, 8'h01 << i);
      leave();
    end
    $display("test dedicated done");
  endtask
  task automatic t_periph();
    int n;
    enter(7, 8'h08, 8'h10, IVL_VEC_PER, 0);
    rd_reg(2'h0, 8'h10);
    rd_reg(2'h2, 8'h10);
    rd_reg(2'h3, 8'h10);
    // Returning with the flag still set must re-enter at once
    leave();
    for (n = 0; n < 4 && vload !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("re-entry", 16'h1, 16'(vload));
    wr_reg(2'h3, 8'h00);
    leave();
    chk("pending", 16'h0, 16'(irq_p));
    $display("test peripheral done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_blocked();
    t_dedicated();
    t_periph();
    final_report();
  end
endmodule

// *** verif/ivl_core_model.sv ***
// Model of the core sequencer and its return stack
`timescale 1ns/1ps
module ivl_core_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bench commands
  input wire logic stall_i,
  input wire logic ret_req_i,
  // Design side
  input wire logic stack_push_i,
  input wire logic [15:0] stack_push_data_i,
  input wire logic stack_pop_i,
  output logic insn_boundary_o,
  output logic [15:0] next_pc_o,
  output logic return_op_o,
  output logic [15:0] stack_top_o
);
  logic [15:0] stack_ff [4];
  logic [1:0] sp_ff;
  // Stall models a multi-cycle instruction holding off the boundary while asserted
  assign insn_boundary_o = !stall_i;
  assign stack_top_o = stack_ff[sp_ff - 2'h1];
  // Pc keeps moving so a stale return address shows up
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      next_pc_o <= 16'h0100;
      return_op_o <= 1'b0;
      sp_ff <= 2'h0;
    end else begin
      next_pc_o <= next_pc_o + 16'h0001;
      return_op_o <= ret_req_i;
      if (stack_push_i) begin
        stack_ff[sp_ff] <= stack_push_data_i;
        sp_ff <= sp_ff + 2'h1;
      end else if (stack_pop_i) begin
        sp_ff <= sp_ff - 2'h1;
      end
    end
  end
endmodule

// *** verif/ivl_properties.sv ***
// Checker of the interrupt vector logic port behaviour
`timescale 1ns/1ps
module ivl_properties (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Observed ports
  input wire logic insn_boundary_i,
  input wire logic [15:0] next_pc_i,
  input wire logic return_from_interrupt_op_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_pending_o,
  input wire logic vector_load_o,
  input wire logic [15:0] vector_pc_o,
  input wire logic stack_push_o,
  input wire logic [15:0] stack_push_data_o,
  input wire logic stack_pop_o,
  input wire logic global_interrupt_disable_o
);
  // ************************************
  // Entry, return, pending and read data relations
  // ************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  entry_sets_disable_a: assert property (vector_load_o |-> global_interrupt_disable_o)
    else $error("entry left disable clear");
  entry_was_allowed_a: assert property (vector_load_o |-> $past(!global_interrupt_disable_o))
    else $error("entry while disabled");
  push_with_load_a: assert property (vector_load_o |-> stack_push_o)
    else $error("entry without push");
  push_data_a: assert property (stack_push_o |-> stack_push_data_o == $past(next_pc_i))
    else $error("wrong return address");
  vector_legal_a: assert property (
    vector_load_o |-> vector_pc_o inside {16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("illegal vector");
  boundary_wait_a: assert property (vector_load_o |-> $past(insn_boundary_i))
    else $error("entry inside an instruction");
  return_pops_a: assert property (
    return_from_interrupt_op_i |=> stack_pop_o && !global_interrupt_disable_o)
    else $error("return did not pop and enable");
  pending_gated_a: assert property (irq_pending_o |-> !global_interrupt_disable_o)
    else $error("pending while disabled");
  single_take_a: assert property (vector_load_o |=> !vector_load_o[*2])
    else $error("second entry follows");
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data without read");
endmodule
bind ivl_top ivl_properties ivl_properties_inst (.ref_clk_i, .rst_n_i, .insn_boundary_i,
  .next_pc_i, .return_from_interrupt_op_i, .rd_i, .rdata_o, .irq_pending_o, .vector_load_o,
  .vector_pc_o, .stack_push_o, .stack_push_data_o, .stack_pop_o, .global_interrupt_disable_o);
